// >>> rtl/lcd_output_mux_bias_frame_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_output_mux_bias_frame_cfg (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                resetn,
   // command bytes from the serial interface
   input  wire logic                cmdValid,
   input  wire logic [7:0]          cmdByte,
   // clock source control
   input  wire logic                extClockSelect,
   input  wire logic                extClockRateFlag,
   input  wire logic                clockOutEnable,
   // clock pin, split
   input  wire logic                clockPinIn,
   output logic                     clockPinOut,
   output logic                     clockPinOe,
   // sources for the shared outputs
   input  wire logic [5:0]          lcdSegIn,
   input  wire logic [5:0]          gpoLevelIn,
   input  wire logic [5:0]          pwmIn,
   // shared outputs and configuration
   output logic [5:0]               sharedOut,
   output lcd_cfg_pkg::cfg_t        cfg,
   output logic [6:0]               divFactorQ,
   output logic                     frameTick
);
   import lcd_cfg_pkg::*;

   cfg_t       cfg_r;
   logic [6:0] q_r;
   logic [9:0] oscCnt_r;
   logic       oscTick;
   logic       clockPinPrev_r;
   logic       extTick;
   logic       baseTick;
   logic       useQ;
   logic       interTick;
   logic       interLevel;
   logic       frameSrcTick;
   logic       isGpm01;
   logic       isGpm23;
   logic       isGpm45;
   logic       isMux;
   logic       isBias;
   logic       isFd;
   logic       fdUsed;

   assign cfg        = cfg_r;
   assign divFactorQ = q_r;

   // opcode decode; top nibbles and six-bit prefixes never overlap
   assign isGpm01 = cmdValid && (cmdByte[7:4] == CMD_GPM01);
   assign isGpm23 = cmdValid && (cmdByte[7:4] == CMD_GPM23);
   assign isGpm45 = cmdValid && (cmdByte[7:4] == CMD_GPM45);
   assign isMux   = cmdValid && (cmdByte[7:2] == CMD_MUX);
   assign isBias  = cmdValid && (cmdByte[7:2] == CMD_BIAS);
   assign isFd    = cmdValid && (cmdByte[7:5] == CMD_FD);
   assign fdUsed  = (cmdByte[4:0] <= FD_LAST_USED);

   // output mode fields, two per command
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_r.pinOutputMode <= {6{MODE_RESET}};
      end else if (isGpm01) begin
         cfg_r.pinOutputMode[1] <= cmdByte[3:2];
         cfg_r.pinOutputMode[0] <= cmdByte[1:0];
      end else if (isGpm23) begin
         cfg_r.pinOutputMode[3] <= cmdByte[3:2];
         cfg_r.pinOutputMode[2] <= cmdByte[1:0];
      end else if (isGpm45) begin
         cfg_r.pinOutputMode[5] <= cmdByte[3:2];
         cfg_r.pinOutputMode[4] <= cmdByte[1:0];
      end
   end

   // multiplex drive field
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_r.muxMode <= MUX_RESET;
      end else if (isMux) begin
         cfg_r.muxMode <= cmdByte[1:0];
      end
   end

   // bias field; encoding is kept raw, 10 and 11 are not in order
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_r.biasMode <= BIAS_RESET;
      end else if (isBias) begin
         cfg_r.biasMode <= cmdByte[1:0];
      end
   end

   // prescaler code and its factor; an unused code changes nothing, so the
   // stored code always matches the factor in use
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_r.lcdFramePrescalerCode <= FD_RESET;
         q_r                         <= q_of_code(FD_RESET);
      end else if (isFd && fdUsed) begin
         cfg_r.lcdFramePrescalerCode <= cmdByte[4:0];
         q_r                         <= q_of_code(cmdByte[4:0]);
      end
   end

   // internal oscillator stands in as an enable pulse from mclk
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         oscCnt_r <= 10'h000;
      end else if (oscTick) begin
         oscCnt_r <= 10'h000;
      end else begin
         oscCnt_r <= 10'(oscCnt_r + 10'h001);
      end
   end
   assign oscTick = (oscCnt_r == 10'(OSC_DIV_CYCLES - 1));

   // clock pin is synchronous to mclk; rising edge gives one source tick
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clockPinPrev_r <= 1'b0;
      end else begin
         clockPinPrev_r <= clockPinIn;
      end
   end
   assign extTick = clockPinIn && !clockPinPrev_r;

   // source select; the rate flag only matters for the external source
   assign baseTick     = extClockSelect ? extTick : oscTick;
   assign useQ         = !extClockSelect || extClockRateFlag;
   assign frameSrcTick = useQ ? interTick : baseTick;

   // divide by q into the intermediate clock
   q_tick_divider u_qdiv (
      .mclk     (mclk),
      .resetn   (resetn),
      .tickIn   (baseTick && useQ),
      .divQ     (q_r),
      .tickOut  (interTick),
      .clkLevel (interLevel)
   );

   // 48 ticks per frame
   frame_tick_counter u_frame (
      .mclk      (mclk),
      .resetn    (resetn),
      .tickIn    (frameSrcTick),
      .frameTick (frameTick)
   );

   // clock pin drive; released whenever the pin is an input
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clockPinOe  <= 1'b0;
         clockPinOut <= 1'b0;
      end else begin
         clockPinOe  <= !extClockSelect && clockOutEnable;
         clockPinOut <= interLevel;
      end
   end

   // per-pin output select, registered so pins never glitch
   for (genvar i = 0; i < 6; i++) begin : g_pin
      always_ff @(posedge mclk) begin
         if (!resetn) begin
            sharedOut[i] <= 1'b0;
         end else begin
            case (cfg_r.pinOutputMode[i])
               MODE_STATIC: sharedOut[i] <= gpoLevelIn[i];
               MODE_PWM:    sharedOut[i] <= pwmIn[i];
               default:     sharedOut[i] <= lcdSegIn[i];
            endcase
         end
      end
   end

   chk_gpm01_load: assert property (@(posedge mclk) disable iff (!resetn)
      isGpm01 |=> cfg_r.pinOutputMode[1] == $past(cmdByte[3:2])
               && cfg_r.pinOutputMode[0] == $past(cmdByte[1:0]))
      else $error("modes 0/1 not loaded");

   chk_gpm23_load: assert property (@(posedge mclk) disable iff (!resetn)
      isGpm23 |=> cfg_r.pinOutputMode[3] == $past(cmdByte[3:2])
               && cfg_r.pinOutputMode[2] == $past(cmdByte[1:0]))
      else $error("modes 2/3 not loaded");

   chk_gpm45_load: assert property (@(posedge mclk) disable iff (!resetn)
      isGpm45 |=> cfg_r.pinOutputMode[5] == $past(cmdByte[3:2])
               && cfg_r.pinOutputMode[4] == $past(cmdByte[1:0]))
      else $error("modes 4/5 not loaded");

   chk_pwm_route: assert property (@(posedge mclk) disable iff (!resetn)
      cfg_r.pinOutputMode[0] == MODE_PWM ##1 $stable(cfg_r.pinOutputMode[0])
      |-> sharedOut[0] == $past(pwmIn[0]))
      else $error("pin 0 not routed to pwm");

   chk_lcd_route: assert property (@(posedge mclk) disable iff (!resetn)
      !cfg_r.pinOutputMode[5][1] |=> sharedOut[5] == $past(lcdSegIn[5]))
      else $error("pin 5 not routed to segment");

   chk_mux_load: assert property (@(posedge mclk) disable iff (!resetn)
      isMux |=> cfg_r.muxMode == $past(cmdByte[1:0]) ##1 $stable(cfg_r.muxMode)
      or ##1 $past(isMux))
      else $error("multiplex field not loaded");

   chk_bias_load: assert property (@(posedge mclk) disable iff (!resetn)
      isBias |=> cfg_r.biasMode == $past(cmdByte[1:0]))
      else $error("bias field not loaded");

   chk_fd_load: assert property (@(posedge mclk) disable iff (!resetn)
      isFd && fdUsed |=> cfg_r.lcdFramePrescalerCode == $past(cmdByte[4:0])
                      && q_r == q_of_code($past(cmdByte[4:0])))
      else $error("prescaler code not loaded");

   chk_fd_unused: assert property (@(posedge mclk) disable iff (!resetn)
      isFd && !fdUsed |=> $stable(q_r) && $stable(cfg_r.lcdFramePrescalerCode))
      else $error("unused code changed the factor");

   chk_slow_direct: assert property (@(posedge mclk) disable iff (!resetn)
      extClockSelect && !extClockRateFlag && extTick |-> frameSrcTick)
      else $error("slow external tick not counted directly");

   chk_pin_release: assert property (@(posedge mclk) disable iff (!resetn)
      extClockSelect ##1 extClockSelect |-> !clockPinOe)
      else $error("clock pin driven with external source");

   chk_pin_drive: assert property (@(posedge mclk) disable iff (!resetn)
      !extClockSelect && clockOutEnable |=> clockPinOe)
      else $error("clock pin not driven when enabled");

   // static level route, checked on a pin that no pwm check covers
   chk_static_route: assert property (@(posedge mclk) disable iff (!resetn)
      cfg_r.pinOutputMode[3] == MODE_STATIC
      |=> sharedOut[3] == $past(gpoLevelIn[3]))
      else $error("pin 3 not routed to static level");

   chk_seg_route: assert property (@(posedge mclk) disable iff (!resetn)
      !cfg_r.pinOutputMode[1][1] |=> sharedOut[1] == $past(lcdSegIn[1]))
      else $error("pin 1 not routed to segment");

   // slow external source: frames come from pin edges only
   chk_slow_edges: assert property (@(posedge mclk) disable iff (!resetn)
      extClockSelect && !extClockRateFlag && frameSrcTick |-> extTick)
      else $error("slow frame tick without a pin edge");

   chk_slow_no_div: assert property (@(posedge mclk) disable iff (!resetn)
      extClockSelect && !extClockRateFlag |=> !interTick)
      else $error("divider ran at the slow rate");

   // fields hold between commands of their own kind
   chk_mode_hold: assert property (@(posedge mclk) disable iff (!resetn)
      !(isGpm01 || isGpm23 || isGpm45) |=> $stable(cfg_r.pinOutputMode))
      else $error("output modes changed without a command");

   chk_mux_hold: assert property (@(posedge mclk) disable iff (!resetn)
      !isMux |=> $stable(cfg_r.muxMode))
      else $error("multiplex field changed without a command");

   chk_bias_hold: assert property (@(posedge mclk) disable iff (!resetn)
      !isBias |=> $stable(cfg_r.biasMode))
      else $error("bias field changed without a command");

   chk_fd_hold: assert property (@(posedge mclk) disable iff (!resetn)
      !isFd |=> $stable(q_r) && $stable(cfg_r.lcdFramePrescalerCode))
      else $error("prescaler changed without a command");

   // opcodes 0100_xxxx, outside this block, leave every field alone
   chk_other_opcode: assert property (@(posedge mclk) disable iff (!resetn)
      cmdValid && cmdByte[7:4] == 4'h4 |=> $stable(cfg_r))
      else $error("foreign opcode changed the configuration");

   // the stored code and the factor in use never drift apart
   chk_q_table: assert property (@(posedge mclk) disable iff (!resetn)
      q_r == q_of_code(cfg_r.lcdFramePrescalerCode))
      else $error("factor does not match stored code");

   chk_frame_pulse: assert property (@(posedge mclk) disable iff (!resetn)
      frameTick |=> !frameTick)
      else $error("frame pulse longer than one cycle");

   chk_pin_idle: assert property (@(posedge mclk) disable iff (!resetn)
      !clockOutEnable |=> !clockPinOe)
      else $error("clock pin driven while output disabled");

   // reset defaults, watched while reset is held
   chk_reset_state: assert property (@(posedge mclk)
      !resetn |=> q_r == q_of_code(FD_RESET)
               && cfg_r.lcdFramePrescalerCode == FD_RESET)
      else $error("prescaler not at default after reset");

   chk_reset_pins: assert property (@(posedge mclk)
      !resetn |=> sharedOut == 6'h00 && !clockPinOe)
      else $error("pins not quiet after reset");

endmodule : lcd_output_mux_bias_frame_cfg
`default_nettype wire

// >>> rtl/lcd_cfg_pkg.sv
// What this block does
// - Command byte 1100_xxxx loads shared output 1 mode from bits 3:2 and output 0 mode from bits 1:0.
// - Command byte 1101_xxxx loads shared output 3 mode from bits 3:2 and output 2 mode from bits 1:0.
// - Command byte 1110_xxxx loads shared output 5 mode from bits 3:2 and output 4 mode from bits 1:0.
// - Each shared output follows its mode: 00/01 LCD segment (default), 10 static level, 11 PWM.
// - Command byte 000000_xx sets the multiplex field: 00/01 1:8 (default), 10 1:6, 11 1:4.
// - Command byte 000001_xx sets the bias field: 00/01 quarter (default), 11 third, 10 half.
// - Command byte 001_xxxxx loads the five-bit LCD frame prescaler code from bits 4:0.
// - With the external clock at the slow rate, one frame comes every 48 clock-pin cycles and the code is ignored.
// - At the fast rate the clock is divided by q into an intermediate clock, and one frame comes per 48 of those.
// - Codes 00000..01111 give q of 80,68,60,53,48,44,40,37,34,32,30,28,27,25,24,23; 01110 is the default.
// - Codes 10000..10110 give q of 22,21,20,19,18,17,16; codes 10111..11111 are unused and leave the stored code and q unchanged.
// - With the internal oscillator the intermediate clock may be presented on the clock pin.
// - The rate flag is 0 for a slow and 1 for a fast external clock and only matters with the external source.
// - The clock pin drives only with the internal oscillator and clock output enabled, otherwise it is released.
package lcd_cfg_pkg;

   // command opcodes
   localparam logic [3:0] CMD_GPM01 = 4'hC;
   localparam logic [3:0] CMD_GPM23 = 4'hD;
   localparam logic [3:0] CMD_GPM45 = 4'hE;
   localparam logic [5:0] CMD_MUX   = 6'h00;
   localparam logic [5:0] CMD_BIAS  = 6'h01;
   localparam logic [2:0] CMD_FD    = 3'h1;

   // field values and reset values
   localparam logic [1:0] MODE_STATIC  = 2'h2;
   localparam logic [1:0] MODE_PWM     = 2'h3;
   localparam logic [1:0] MODE_RESET   = 2'h0;
   localparam logic [1:0] MUX_RESET    = 2'h0;
   localparam logic [1:0] BIAS_RESET   = 2'h0;
   localparam logic [4:0] FD_RESET     = 5'h0E;
   localparam logic [4:0] FD_LAST_USED = 5'h16;

   // timing
   localparam int         MCLK_FREQ_HZ    = 125000000;
   localparam int         OSC_FREQ_HZ     = 230000;
   localparam int         OSC_DIV_CYCLES  = MCLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam logic [5:0] TICKS_PER_FRAME = 6'h30;

   // configuration carried to the rest of the display logic
   typedef struct packed {
      logic [5:0][1:0] pinOutputMode;
      logic [1:0]      muxMode;
      logic [1:0]      biasMode;
      logic [4:0]      lcdFramePrescalerCode;
   } cfg_t;

   // prescaler code to divide factor q
   function automatic logic [6:0] q_of_code(input logic [4:0] code);
      logic [6:0] q;
      q = 7'h18;
      case (code)
         5'h00: q = 7'h50;
         5'h01: q = 7'h44;
         5'h02: q = 7'h3C;
         5'h03: q = 7'h35;
         5'h04: q = 7'h30;
         5'h05: q = 7'h2C;
         5'h06: q = 7'h28;
         5'h07: q = 7'h25;
         5'h08: q = 7'h22;
         5'h09: q = 7'h20;
         5'h0A: q = 7'h1E;
         5'h0B: q = 7'h1C;
         5'h0C: q = 7'h1B;
         5'h0D: q = 7'h19;
         5'h0E: q = 7'h18;
         5'h0F: q = 7'h17;
         5'h10: q = 7'h16;
         5'h11: q = 7'h15;
         5'h12: q = 7'h14;
         5'h13: q = 7'h13;
         5'h14: q = 7'h12;
         5'h15: q = 7'h11;
         5'h16: q = 7'h10;
         default: q = 7'h18;
      endcase
      return q;
   endfunction : q_of_code

endpackage : lcd_cfg_pkg

// >>> rtl/q_tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module q_tick_divider (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // source tick and factor
   input  wire logic       tickIn,
   input  wire logic [6:0] divQ,
   // intermediate clock
   output logic            tickOut,
   output logic            clkLevel
);
   import lcd_cfg_pkg::*;

   logic [6:0] cnt_r;
   logic [6:0] cntNxt;

   // wrap at q-1; a shrinking q is caught by the compare
   assign cntNxt = (cnt_r >= 7'(divQ - 7'h01)) ? 7'h00 : 7'(cnt_r + 7'h01);

   // one intermediate tick per q source ticks
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cnt_r   <= 7'h00;
         tickOut <= 1'b0;
      end else begin
         tickOut <= tickIn && (cntNxt == 7'h00);
         if (tickIn) begin
            cnt_r <= cntNxt;
         end
      end
   end

   // duty follows q: high for the first half of each period
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clkLevel <= 1'b0;
      end else if (tickIn) begin
         clkLevel <= (cntNxt < (divQ >> 1));
      end
   end

   chk_q_period: assert property (@(posedge mclk) disable iff (!resetn)
      tickOut && $stable(divQ) |-> $past(cnt_r) == 7'(divQ - 7'h01))
      else $error("intermediate tick not at q-1");

endmodule : q_tick_divider
`default_nettype wire

// >>> rtl/frame_tick_counter.sv
`timescale 1ns/1ps
`default_nettype none
module frame_tick_counter (
   // clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // tick in, frame out
   input  wire logic tickIn,
   output logic      frameTick
);
   import lcd_cfg_pkg::*;

   logic [5:0] cnt_r;
   logic [6:0] seen_r;

   // 48 ticks make one frame
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cnt_r     <= 6'h00;
         frameTick <= 1'b0;
      end else begin
         frameTick <= tickIn && (cnt_r == 6'(TICKS_PER_FRAME - 6'h01));
         if (tickIn) begin
            cnt_r <= (cnt_r == 6'(TICKS_PER_FRAME - 6'h01)) ? 6'h00
                                                            : 6'(cnt_r + 6'h01);
         end
      end
   end

   // helper: ticks counted since the previous frame
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         seen_r <= 7'h00;
      end else if (frameTick) begin
         seen_r <= {6'h00, tickIn};
      end else if (tickIn && seen_r != 7'h7F) begin
         seen_r <= 7'(seen_r + 7'h01);
      end
   end

   chk_frame_spacing: assert property (@(posedge mclk) disable iff (!resetn)
      frameTick |-> seen_r == {1'b0, TICKS_PER_FRAME})
      else $error("frame not after 48 ticks");

endmodule : frame_tick_counter
`default_nettype wire

// >>> tb/cmd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_host_model (
   // clock
   input  wire logic       mclk,
   // command strobe and byte
   output logic            cmdValid,
   output logic [7:0]      cmdByte,
   // external clock drive, low while idle
   output logic            extClk
);
   // quiet bus at time zero
   initial begin
      cmdValid = 1'h0;
      cmdByte  = 8'hA5;
      extClk   = 1'h0;
   end

   // one whole byte per strobe, taken at the next edge; call on an edge
   task automatic sendCmd(input logic [7:0] b);
      cmdValid <= 1'h1;
      cmdByte  <= b;
      @(posedge mclk);
   endtask : sendCmd

   // byte is inverted on release so a stale value never looks valid
   task automatic idle();
      cmdValid <= 1'h0;
      cmdByte  <= ~cmdByte;
      @(posedge mclk);
   endtask : idle

   // one period of the external clock, six mclk long, stands low after
   task automatic extEdge();
      extClk <= 1'h1;
      repeat (3) @(posedge mclk);
      extClk <= 1'h0;
      repeat (3) @(posedge mclk);
   endtask : extEdge
endmodule : cmd_host_model
`default_nettype wire

// >>> tb/lcd_output_mux_bias_frame_cfg_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_output_mux_bias_frame_cfg_test;
   import lcd_cfg_pkg::*;

   logic       mclk             = 1'h0;
   logic       resetn           = 1'h0;
   logic       cmdValid;
   logic [7:0] cmdByte;
   logic       extClockSelect   = 1'h1;
   logic       extClockRateFlag = 1'h0;
   logic       clockOutEnable   = 1'h0;
   logic       extClk;
   logic       clockPinIn;
   logic       clockPinOut;
   logic       clockPinOe;
   logic [5:0] lcdSegIn         = 6'h15;
   logic [5:0] gpoLevelIn       = 6'h2A;
   logic [5:0] pwmIn            = 6'h00;
   logic [5:0] sharedOut;
   cfg_t       cfg;
   cfg_t       expCfg;
   logic [6:0] divFactorQ;
   logic       frameTick;
   logic       old;
   int         failCount        = 0;
   int         nChecks          = 0;
   int         cycles           = 0;
   int         frameCnt         = 0;
   int         n;
   int         rises;

   // command byte beside the q it should leave behind
   localparam logic [14:0] ROWS [40] = '{
      {8'hC7,7'h18}, {8'hD9,7'h18}, {8'hE6,7'h18}, {8'hCE,7'h18},
      {8'hDB,7'h18}, {8'hEF,7'h18}, {8'h00,7'h18}, {8'h01,7'h18},
      {8'h02,7'h18}, {8'h03,7'h18}, {8'h04,7'h18}, {8'h05,7'h18},
      {8'h06,7'h18}, {8'h07,7'h18}, {8'h20,7'h50}, {8'h21,7'h44},
      {8'h22,7'h3C}, {8'h23,7'h35}, {8'h24,7'h30}, {8'h25,7'h2C},
      {8'h26,7'h28}, {8'h27,7'h25}, {8'h28,7'h22}, {8'h29,7'h20},
      {8'h2A,7'h1E}, {8'h2B,7'h1C}, {8'h2C,7'h1B}, {8'h2D,7'h19},
      {8'h2E,7'h18}, {8'h2F,7'h17}, {8'h30,7'h16}, {8'h31,7'h15},
      {8'h32,7'h14}, {8'h33,7'h13}, {8'h34,7'h12}, {8'h35,7'h11},
      {8'h36,7'h10}, {8'h37,7'h10}, {8'h3F,7'h10}, {8'h40,7'h10}
   };
   // sel, enable, expected drive of the clock pin
   localparam logic [2:0] OE_ROWS [3] = '{3'h0, 3'h6, 3'h3};

   cmd_host_model i_cmd_host_model (
      .mclk     (mclk),
      .cmdValid (cmdValid),
      .cmdByte  (cmdByte),
      .extClk   (extClk)
   );

   lcd_output_mux_bias_frame_cfg i_lcd_output_mux_bias_frame_cfg (
      .mclk, .resetn, .cmdValid, .cmdByte, .extClockSelect,
      .extClockRateFlag, .clockOutEnable, .clockPinIn, .clockPinOut,
      .clockPinOe, .lcdSegIn, .gpoLevelIn, .pwmIn, .sharedOut, .cfg,
      .divFactorQ, .frameTick
   );

   always #4 mclk = ~mclk;

   // pin level: the block wins while it drives, else the host clock
   assign clockPinIn = clockPinOe ? clockPinOut : extClk;

   // cycle ceiling and frame count; a hang lands in the report
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (frameTick === 1'h1) frameCnt <= frameCnt + 1;
      if (cycles == 60000) begin
         failCount++;
         results();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // expected fields after one byte; unused codes leave the code alone
   task automatic model(input logic [7:0] b);
      case (b[7:4])
         4'hC: expCfg.pinOutputMode[1:0] = b[3:0];
         4'hD: expCfg.pinOutputMode[3:2] = b[3:0];
         4'hE: expCfg.pinOutputMode[5:4] = b[3:0];
         default: ;
      endcase
      if (b[7:2] == 6'h00) expCfg.muxMode = b[1:0];
      if (b[7:2] == 6'h01) expCfg.biasMode = b[1:0];
      if (b[7:5] == 3'h1 && b[4:0] <= 5'h16)
         expCfg.lcdFramePrescalerCode = b[4:0];
   endtask : model

   function automatic logic [5:0] expShared(input cfg_t c);
      logic [5:0] r;
      for (int i = 0; i < 6; i++) begin
         r[i] = (c.pinOutputMode[i] == 2'h3) ? pwmIn[i] :
                (c.pinOutputMode[i] == 2'h2) ? gpoLevelIn[i] : lcdSegIn[i];
      end
      return r;
   endfunction : expShared

   // defaults are looked at while reset is still held
   task automatic doReset();
      resetn <= 1'h0;
      repeat (5) @(posedge mclk);
      #1;
      expCfg = '0;
      expCfg.lcdFramePrescalerCode = 5'h0E;
      check("cfg", cfg, expCfg);
      check("divFactorQ", divFactorQ, 7'h18);
      check("clockPinOe", clockPinOe, 1'h0);
      check("sharedOut", sharedOut, 6'h00);
      @(posedge mclk);
      resetn <= 1'h1;
   endtask : doReset

   // sync on one frame, then count source edges up to the next one
   task automatic framePeriod(input int expEdges);
      int start;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         start = frameCnt;
         while (frameCnt == start && n < 2 * expEdges) begin
            i_cmd_host_model.extEdge();
            n++;
         end
      end
      check("frameEdges", n, expEdges);
   endtask : framePeriod

   task automatic results();
      if (failCount == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   initial begin
      doReset();
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk);
         pwmIn <= {6{i[0]}};
         i_cmd_host_model.sendCmd(ROWS[i][14:7]);
         i_cmd_host_model.idle();
         model(ROWS[i][14:7]);
         #1 check("cfg", cfg, expCfg);
         check("divFactorQ", divFactorQ, ROWS[i][6:0]);
         @(posedge mclk);
         #1 check("sharedOut", sharedOut, expShared(expCfg));
      end
      // slow external clock ignores the code, fast one divides by q=16
      @(posedge mclk);
      framePeriod(48);
      extClockRateFlag <= 1'h1;
      framePeriod(768);
      for (int i = 0; i < 3; i++) begin
         extClockSelect <= OE_ROWS[i][2];
         clockOutEnable <= OE_ROWS[i][1];
         repeat (3) @(posedge mclk);
         #1 check("clockPinOe", clockPinOe, OE_ROWS[i][0]);
         @(posedge mclk);
      end
      // intermediate clock on the pin: one period is q oscillator ticks
      n = 0;
      rises = 0;
      while (rises < 2 && n < 20000) begin
         old = clockPinOut;
         @(posedge mclk);
         #1;
         n++;
         if (old === 1'h0 && clockPinOut === 1'h1) begin
            rises++;
            if (rises == 1) n = 0;
         end
      end
      check("clockPeriod", n, 16 * OSC_DIV_CYCLES);
      // mid-run reset, then commands on consecutive edges
      @(posedge mclk);
      doReset();
      @(posedge mclk);
      i_cmd_host_model.sendCmd(8'hC5);
      i_cmd_host_model.sendCmd(8'hD6);
      i_cmd_host_model.sendCmd(8'h2F);
      i_cmd_host_model.idle();
      model(8'hC5);
      model(8'hD6);
      model(8'h2F);
      #1 check("cfg", cfg, expCfg);
      check("divFactorQ", divFactorQ, 7'h17);
      results();
   end
endmodule : lcd_output_mux_bias_frame_cfg_test
`default_nettype wire
